// ==== rtl/fastlock_resync_timer_sdm.v ====
// Purpose: fast lock timer, phase resync timer and fractional modulator control
// Assumes: serial pins and PFD reference come from outside and are synchronised here
// Notes: timers count PFD reference cycles, one per rising edge of the reference
`timescale 1ns/1ps
`include "fastlock_resync_defs.vh"
module fastlock_resync_timer_sdm #(
  parameter W = 12
) (
  // clock and reset
  input wire i_clk,
  input wire i_rst,
  // serial configuration pins
  input wire i_sclk,
  input wire i_sdata,
  input wire i_load_enable,
  // PFD reference
  input wire i_pfd_ref,
  // fast lock outputs
  output reg o_wide_bw,
  output reg [4:0] o_cp_gain,
  output reg o_fast_lock_switch_oe,
  output reg o_fast_lock_switch_out,
  // resync outputs
  output reg o_sync_pulse,
  output reg o_phase_align,
  // modulator
  output reg signed [3:0] o_sdm_code,
  output reg [W-1:0] o_fractional_modulus,
  output reg [W-1:0] o_phase_word,
  output reg o_dither
);
  //----------------------------------------
  // input synchronisers
  //----------------------------------------
  reg [1:0] sclk_s_r;
  reg [1:0] sdata_s_r;
  reg [1:0] load_enable_s_r;
  reg [1:0] pfd_s_r;
  reg pfd_d_r;

  always @(posedge i_clk) begin
    if (i_rst) begin
      sclk_s_r <= 2'b00;
      sdata_s_r <= 2'b00;
      load_enable_s_r <= 2'b00;
      pfd_s_r <= 2'b00;
      pfd_d_r <= 1'b0;
    end else begin
      sclk_s_r <= {sclk_s_r[0], i_sclk};
      sdata_s_r <= {sdata_s_r[0], i_sdata};
      load_enable_s_r <= {load_enable_s_r[0], i_load_enable};
      pfd_s_r <= {pfd_s_r[0], i_pfd_ref};
      pfd_d_r <= pfd_s_r[1];
    end
  end

  wire pfd_tick = pfd_s_r[1] & ~pfd_d_r;

  //----------------------------------------
  // configuration latches
  //----------------------------------------
  wire [`WORD_BITS-1:0] word;
  wire word_valid;

  serial_config_port u_port (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_sclk(sclk_s_r[1]),
    .i_sdata(sdata_s_r[1]),
    .i_load_enable(load_enable_s_r[1]),
    .o_word(word),
    .o_word_valid(word_valid)
  );

  wire [2:0] addr = word[`ADDR_MSB:`ADDR_LSB];
  wire [W-1:0] field = word[`FIELD_MSB:`FIELD_LSB];

  reg [W-1:0] modulus_r;
  reg [W-1:0] phase_r;
  reg [W-1:0] frac_r;
  reg [W-1:0] clk_div_r;
  reg [1:0] mode_r;
  reg dither_r;
  reg load_r;
  reg seed_r;

  always @(posedge i_clk) begin
    if (i_rst) begin
      modulus_r <= `MODULUS_RESET;
      phase_r <= {W{1'b0}};
      frac_r <= {W{1'b0}};
      clk_div_r <= `DIV_RESET;
      mode_r <= `MODE_OFF;
      dither_r <= 1'b0;
      load_r <= 1'b0;
      seed_r <= 1'b0;
    end else begin
      load_r <= 1'b0;
      seed_r <= 1'b0;
      if (word_valid) begin
        load_r <= 1'b1;
        case (addr)
          `ADDR_R1: begin
            // values below 2 are held at 2 so the modulator stays defined
            modulus_r <= (field < `MODULUS_RESET) ? `MODULUS_RESET : field;
            phase_r <= word[`PHASE_MSB:`PHASE_LSB];
            seed_r <= 1'b1;
          end
          `ADDR_R2: begin
            dither_r <= word[`DITHER_BIT];
          end
          `ADDR_R3: begin
            mode_r <= word[`MODE_MSB:`MODE_LSB];
            clk_div_r <= field;
          end
          `ADDR_R0: begin
            // word 0 carries the fractional value in the same field
            frac_r <= field;
          end
          default: begin
            // words 4 to 7 hold settings outside this block
          end
        endcase
      end
    end
  end

  //----------------------------------------
  // modulator
  //----------------------------------------
  wire signed [3:0] code;
  // phase word at or beyond the modulus has it subtracted once, so the seed is below the modulus only for phase words below twice the modulus
  wire [W-1:0] seed_val = (phase_r >= modulus_r) ? phase_r - modulus_r : phase_r;

  sigma_delta_mod3 #(.W(W)) u_sdm (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_step(pfd_tick),
    .i_seed(seed_r),
    .i_dither(dither_r),
    .i_frac(frac_r),
    .i_fractional_modulus(modulus_r),
    .i_phase(seed_val),
    .o_code(code)
  );

  //----------------------------------------
  // interval timers, two nested counters
  //----------------------------------------
  // inner counts modulus PFD periods, outer counts divider value
  reg [W-1:0] inner_r;
  reg [W-1:0] outer_r;
  reg fast_active_r;
  reg [1:0] sync_cnt_r;
  reg align_wait_r;

  // one at the counter width, so compares and increments keep W bits
  localparam [W-1:0] ONE_W = {{(W-1){1'b0}}, 1'b1};
  wire inner_wrap = pfd_tick && (inner_r == modulus_r - ONE_W);
  wire outer_wrap = inner_wrap && (outer_r == clk_div_r - ONE_W);
  wire resync_on = (mode_r == `MODE_RESYNC);

  always @(posedge i_clk) begin
    if (i_rst) begin
      inner_r <= {W{1'b0}};
      outer_r <= {W{1'b0}};
      fast_active_r <= 1'b0;
      sync_cnt_r <= 2'b00;
      align_wait_r <= 1'b0;
      o_sync_pulse <= 1'b0;
      o_phase_align <= 1'b0;
    end else begin
      o_sync_pulse <= 1'b0;
      o_phase_align <= 1'b0;
      if (load_r) begin
        // every load restarts the interval so timing runs from load enable
        inner_r <= {W{1'b0}};
        outer_r <= {W{1'b0}};
        fast_active_r <= (mode_r == `MODE_FASTLOCK) && (clk_div_r != {W{1'b0}});
        sync_cnt_r <= 2'b00;
        align_wait_r <= resync_on;
      end else if (mode_r == `MODE_OFF) begin
        fast_active_r <= 1'b0;
        align_wait_r <= 1'b0;
      end else if (pfd_tick && (fast_active_r || resync_on)) begin
        inner_r <= inner_wrap ? {W{1'b0}} : inner_r + ONE_W;
        if (inner_wrap)
          outer_r <= outer_wrap ? {W{1'b0}} : outer_r + ONE_W;
        if (outer_wrap) begin
          fast_active_r <= 1'b0;
          if (resync_on) begin
            o_sync_pulse <= 1'b1;
            if (align_wait_r) begin
              if (sync_cnt_r == `SYNC_TO_ALIGN - 2'h1) begin
                o_phase_align <= 1'b1;
                align_wait_r <= 1'b0;
              end
              sync_cnt_r <= sync_cnt_r + 2'h1;
            end
          end
        end
      end
    end
  end

  //----------------------------------------
  // registered outputs
  //----------------------------------------
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_wide_bw <= 1'b0;
      o_cp_gain <= `CP_GAIN_NORMAL;
      o_fast_lock_switch_oe <= 1'b0;
      o_fast_lock_switch_out <= 1'b0;
      o_sdm_code <= 4'sh0;
      o_fractional_modulus <= `MODULUS_RESET;
      o_phase_word <= {W{1'b0}};
      o_dither <= 1'b0;
    end else begin
      o_wide_bw <= fast_active_r;
      o_cp_gain <= fast_active_r ? `CP_GAIN_FAST : `CP_GAIN_NORMAL;
      o_fast_lock_switch_oe <= fast_active_r;
      o_fast_lock_switch_out <= 1'b0;
      o_sdm_code <= code;
      o_fractional_modulus <= modulus_r;
      o_phase_word <= phase_r;
      o_dither <= dither_r;
    end
  end
endmodule // fastlock_resync_timer_sdm

// ==== rtl/fastlock_resync_defs.vh ====
// Purpose: constants for the fast lock / phase resync timer and fractional modulator
// Assumes: one 40 MHz clock, PFD reference events arrive as a pin
// Notes: configuration words are 32 bits, address in bits 2:0
//
// Contract
// - mode field 01 enters fast lock, divider value is the wide-bandwidth count
// - wide bandwidth lasts timer value times modulus PFD periods
// - charge pump current multiplied by 16 during wide bandwidth
// - fast lock switch grounded during the wide-bandwidth interval
// - third-order sigma-delta modulator, modulus 2 to 4095
// - modulator steps once per PFD reference cycle
// - dither off repeat length follows modulus divisibility by 2, 3, 6
// - dither on repeat length is 2^21 cycles whatever the modulus
// - phase word seeds the modulator
// - mode 10 enables resync, sync pulse every divider times modulus PFD periods
// - phase realigns on the second sync pulse after load enable rises
// - modulus taken from bits 14:3 of configuration word 1
// - 32 bits shifted on rising clock, latched when load enable rises
// - phase word 0..modulus steps output phase by 360 over modulus
`ifndef FASTLOCK_RESYNC_DEFS_VH
`define FASTLOCK_RESYNC_DEFS_VH

`define WORD_BITS 32
`define ADDR_LSB 0
`define ADDR_MSB 2
`define FIELD_LSB 3
`define FIELD_MSB 14
`define PHASE_LSB 15
`define PHASE_MSB 26
`define MODE_LSB 15
`define MODE_MSB 16
`define DITHER_BIT 29
`define ADDR_R0 3'h0
`define ADDR_R1 3'h1
`define ADDR_R2 3'h2
`define ADDR_R3 3'h3
`define MODE_OFF 2'h0
`define MODE_FASTLOCK 2'h1
`define MODE_RESYNC 2'h2
`define MODULUS_RESET 12'h0002
`define DIV_RESET 12'h0001
`define CP_GAIN_NORMAL 5'h01
`define CP_GAIN_FAST 5'h10
`define LFSR_RESET 21'h00_0001
`define SYNC_TO_ALIGN 2'h2

`endif

// ==== rtl/serial_config_port.v ====
// Purpose: 32-bit shift register for configuration words
// Assumes: serial clock, data and load enable already synchronised to i_clk
// Notes: a word is handed over in the cycle after load enable rises
`timescale 1ns/1ps
`include "fastlock_resync_defs.vh"
module serial_config_port (
  // clock and reset
  input wire i_clk,
  input wire i_rst,
  // synchronised serial pins
  input wire i_sclk,
  input wire i_sdata,
  input wire i_load_enable,
  // received word
  output reg [`WORD_BITS-1:0] o_word,
  output reg o_word_valid
);
  reg sclk_d_r;
  reg load_enable_d_r;
  reg [`WORD_BITS-1:0] shift_r;

  always @(posedge i_clk) begin
    if (i_rst) begin
      sclk_d_r <= 1'b0;
      load_enable_d_r <= 1'b0;
      shift_r <= {`WORD_BITS{1'b0}};
      o_word <= {`WORD_BITS{1'b0}};
      o_word_valid <= 1'b0;
    end else begin
      sclk_d_r <= i_sclk;
      load_enable_d_r <= i_load_enable;
      o_word_valid <= 1'b0;
      if (i_sclk && !sclk_d_r)
        shift_r <= {shift_r[`WORD_BITS-2:0], i_sdata};
      if (i_load_enable && !load_enable_d_r) begin
        o_word <= shift_r;
        o_word_valid <= 1'b1;
      end
    end
  end
endmodule // serial_config_port

// ==== rtl/sigma_delta_mod3.v ====
// Purpose: third-order MASH fractional interpolator
// Assumes: i_step pulses once per PFD reference cycle
// Notes: dither adds an LFSR lsb into the first accumulator
`timescale 1ns/1ps
`include "fastlock_resync_defs.vh"
module sigma_delta_mod3 #(
  parameter W = 12
) (
  // clock and reset
  input wire i_clk,
  input wire i_rst,
  // control
  input wire i_step,
  input wire i_seed,
  input wire i_dither,
  input wire [W-1:0] i_frac,
  input wire [W-1:0] i_fractional_modulus,
  input wire [W-1:0] i_phase,
  // output code offset to the integer divide
  output reg signed [3:0] o_code
);
  reg [W-1:0] acc1_r;
  reg [W-1:0] acc2_r;
  reg [W-1:0] acc3_r;
  reg c2_d_r;
  reg c3_d_r;
  reg c3_dd_r;
  reg [20:0] lfsr_r;

  // modular add; returns {carry, sum}
  function [W:0] wrap_add;
    input [W-1:0] a;
    input [W-1:0] b;
    input [W-1:0] m;
    reg [W:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      if (s >= {1'b0, m})
        wrap_add = {1'b1, s[W-1:0] - m};
      else
        wrap_add = {1'b0, s[W-1:0]};
    end
  endfunction

  wire [W-1:0] in1 = i_frac + {{(W-1){1'b0}}, i_dither & lfsr_r[0]};
  wire [W:0] s1 = wrap_add(acc1_r, in1, i_fractional_modulus);
  wire [W:0] s2 = wrap_add(acc2_r, s1[W-1:0], i_fractional_modulus);
  wire [W:0] s3 = wrap_add(acc3_r, s2[W-1:0], i_fractional_modulus);

  always @(posedge i_clk) begin
    if (i_rst) begin
      acc1_r <= {W{1'b0}};
      acc2_r <= {W{1'b0}};
      acc3_r <= {W{1'b0}};
      c2_d_r <= 1'b0;
      c3_d_r <= 1'b0;
      c3_dd_r <= 1'b0;
      lfsr_r <= `LFSR_RESET;
      o_code <= 4'sh0;
    end else if (i_seed) begin
      acc1_r <= i_phase;
      acc2_r <= {W{1'b0}};
      acc3_r <= {W{1'b0}};
      c2_d_r <= 1'b0;
      c3_d_r <= 1'b0;
      c3_dd_r <= 1'b0;
    end else if (i_step) begin
      // three cascaded accumulators give third-order noise shaping
      acc1_r <= s1[W-1:0];
      acc2_r <= s2[W-1:0];
      acc3_r <= s3[W-1:0];
      c2_d_r <= s2[W];
      c3_d_r <= s3[W];
      c3_dd_r <= c3_d_r;
      // 21-bit maximal LFSR, period 2^21-1 steps
      lfsr_r <= {lfsr_r[19:0], lfsr_r[20] ^ lfsr_r[18]};
      o_code <= $signed({3'b000, s1[W]}) + $signed({3'b000, s2[W]}) - $signed({3'b000, c2_d_r})
        + $signed({3'b000, s3[W]}) - $signed({2'b00, c3_d_r, 1'b0}) + $signed({3'b000, c3_dd_r});
    end
  end
endmodule // sigma_delta_mod3

// ==== tb/fastlock_resync_props.sv ====
// Purpose: port checker for the fast lock / resync block
// Assumes: one clock, synchronous active-high reset
// Notes: attached by bind, watches outputs only
`timescale 1ns/1ps
module fastlock_resync_props #(
  parameter W = 12
) (
  input wire i_clk,
  input wire i_rst,
  input wire o_wide_bw,
  input wire [4:0] o_cp_gain,
  input wire o_fast_lock_switch_oe,
  input wire o_fast_lock_switch_out,
  input wire o_sync_pulse,
  input wire o_phase_align,
  input wire signed [3:0] o_sdm_code,
  input wire [W-1:0] o_fractional_modulus
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_gain_fast; o_wide_bw |-> o_cp_gain == 5'h10; endproperty
  property p_gain_norm; !o_wide_bw |-> o_cp_gain == 5'h01; endproperty
  property p_switch_on; o_wide_bw |-> o_fast_lock_switch_oe && !o_fast_lock_switch_out; endproperty
  property p_switch_off; $fell(o_wide_bw) |-> !o_fast_lock_switch_oe; endproperty
  property p_sync_one; o_sync_pulse |=> !o_sync_pulse; endproperty
  property p_align; o_phase_align |-> o_sync_pulse; endproperty
  property p_code; o_sdm_code >= -4'sd3 && o_sdm_code <= 4'sd4; endproperty
  property p_modulus_min; o_fractional_modulus >= 2; endproperty
  a_gain_fast: assert property (p_gain_fast) else $error("gain not raised");
  a_gain_norm: assert property (p_gain_norm) else $error("gain not normal");
  a_switch_on: assert property (p_switch_on) else $error("switch not grounded");
  a_switch_off: assert property (p_switch_off) else $error("switch still driven");
  a_sync_one: assert property (p_sync_one) else $error("sync pulse too long");
  a_align: assert property (p_align) else $error("align off a sync pulse");
  a_code: assert property (p_code) else $error("code out of range");
  a_modulus_min: assert property (p_modulus_min) else $error("modulus below two");
  c_fast: cover property ($rose(o_wide_bw));
  c_sync: cover property (o_sync_pulse);
  c_align: cover property (o_phase_align);
endmodule // fastlock_resync_props
bind fastlock_resync_timer_sdm fastlock_resync_props #(.W(W)) u_props (.i_clk(i_clk), .i_rst(i_rst),
  .o_wide_bw(o_wide_bw), .o_cp_gain(o_cp_gain), .o_fast_lock_switch_oe(o_fast_lock_switch_oe),
  .o_fast_lock_switch_out(o_fast_lock_switch_out), .o_sync_pulse(o_sync_pulse),
  .o_phase_align(o_phase_align), .o_sdm_code(o_sdm_code), .o_fractional_modulus(o_fractional_modulus));

// ==== tb/host_serial_model.sv ====
// Purpose: host writing 32-bit configuration words on the serial pins
// Assumes: pins move on falling edges, serial clock levels held 4 cycles, data bits and load enable 8
// Notes: busy drops as load enable rises, so timers can be watched at once
`timescale 1ns/1ps
module host_serial_model (
  // clock
  input wire i_clk,
  // request
  input wire i_start,
  input wire [31:0] i_word,
  // serial pins
  output reg o_sclk = 1'b0,
  output reg o_sdata = 1'b0,
  output reg o_load_enable = 1'b0,
  output reg o_busy = 1'b0
);
  integer i;
  always @(negedge i_clk) begin
    if (i_start) begin
      o_busy <= 1'b1;
      for (i = 31; i >= 0; i = i - 1) begin
        o_sdata <= i_word[i];
        repeat (4) @(negedge i_clk);
        o_sclk <= 1'b1;
        repeat (4) @(negedge i_clk);
        o_sclk <= 1'b0;
      end
      // no pull on the data line, so show it changing after the frame
      o_sdata <= ~i_word[0];
      repeat (4) @(negedge i_clk);
      o_load_enable <= 1'b1;
      o_busy <= 1'b0;
      repeat (8) @(negedge i_clk);
      o_load_enable <= 1'b0;
    end
  end
endmodule // host_serial_model

// ==== tb/testbench.sv ====
// Purpose: self-checking bench for the fast lock / resync block
// Assumes: PFD reference period of 8 clocks
// Notes: timer lengths measured in clocks and converted to PFD periods
`timescale 1ns/1ps
module testbench;
  reg i_clk = 1'b0;
  reg i_rst = 1'b1;
  reg i_pfd_ref = 1'b0;
  reg start = 1'b0;
  reg [31:0] word = 32'h0000_0000;
  reg signed [3:0] s [0:19];
  wire sclk, sdata, load_enable, busy, o_wide_bw, oe, switch_out, o_sync_pulse, o_phase_align, o_dither;
  wire [4:0] o_cp_gain;
  wire signed [3:0] o_sdm_code;
  wire [11:0] o_fractional_modulus, o_phase_word;
  integer failures = 0, compares = 0, np, gap, al, wh, wg, k;
  always #12.5 i_clk = ~i_clk;
  always #100 i_pfd_ref = ~i_pfd_ref;
  host_serial_model host (.i_clk(i_clk), .i_start(start), .i_word(word), .o_sclk(sclk),
    .o_sdata(sdata), .o_load_enable(load_enable), .o_busy(busy));
  fastlock_resync_timer_sdm #(.W(12)) DUT (.i_clk(i_clk), .i_rst(i_rst), .i_sclk(sclk),
    .i_sdata(sdata), .i_load_enable(load_enable), .i_pfd_ref(i_pfd_ref), .o_wide_bw(o_wide_bw),
    .o_cp_gain(o_cp_gain), .o_fast_lock_switch_oe(oe), .o_fast_lock_switch_out(switch_out),
    .o_sync_pulse(o_sync_pulse), .o_phase_align(o_phase_align), .o_sdm_code(o_sdm_code),
    .o_fractional_modulus(o_fractional_modulus), .o_phase_word(o_phase_word), .o_dither(o_dither));
  function [31:0] wd(input [2:0] a, input [16:0] hi, input [11:0] f);
    wd = {hi, f, a};
  endfunction
  task test_done;
    begin
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input [95:0] nm, input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("unexpected %0s expected %0h seen %0h", nm, exp, seen);
      end
    end
  endtask
  task wr(input [31:0] w);
    integer n;
    begin
      repeat (16) @(negedge i_clk);
      word <= w;
      start <= 1'b1;
      @(negedge i_clk);
      start <= 1'b0;
      @(negedge i_clk);
      n = 0;
      while (busy === 1'b1 && n < 400) begin
        @(negedge i_clk);
        n = n + 1;
      end
      if (n >= 400) begin
        failures = failures + 1;
        test_done;
      end
    end
  endtask
  task watch;
    integer j, p1;
    begin
      np = 0; gap = 0; al = 0; wh = 0; wg = 0; p1 = 0;
      for (j = 0; j < 300; j = j + 1) begin
        @(negedge i_clk);
        if (o_wide_bw === 1'b1) wh = wh + 1;
        if (o_wide_bw === 1'b1 && o_cp_gain === 5'h10 && oe === 1'b1 && switch_out === 1'b0) wg = wg + 1;
        if (o_sync_pulse === 1'b1) begin
          np = np + 1;
          if (np == 1) p1 = j;
          if (np == 2) gap = j - p1;
          if (o_phase_align === 1'b1 && al == 0) al = np;
        end
      end
    end
  endtask
  initial begin
    repeat (20) @(negedge i_clk);
    i_rst <= 1'b0;
    @(negedge i_clk);
    chk("gain_rst", o_cp_gain, 5'h01);
    chk("modulus_rst", o_fractional_modulus, 12'h002);
    // power-up sequence, highest register first
    wr(wd(3'h5, 17'h0_0000, 12'h000));
    wr(wd(3'h4, 17'h0_0100, 12'h000));
    wr(wd(3'h3, 17'h0_0000, 12'h000));
    wr(wd(3'h2, 17'h0_0000, 12'h000));
    wr(wd(3'h1, 17'h0_0003, 12'h005));
    wr(wd(3'h0, 17'h0_0000, 12'h002));
    watch;
    chk("modulus_r1", o_fractional_modulus, 12'h005);
    chk("phase", o_phase_word, 12'h003);
    chk("pulses_off", np, 0);
    chk("wide_off", wh, 0);
    for (k = 0; k < 20; k = k + 1) begin
      repeat (8) @(negedge i_clk);
      s[k] = o_sdm_code;
    end
    for (k = 0; k < 15; k = k + 1)
      chk("repeat", s[k+5], s[k]);
    wr(wd(3'h3, 17'h0_0001, 12'h003));
    watch;
    chk("fl_periods", (wh + 7) / 8, 15);
    chk("fl_pulses", np, 0);
    chk("fl_gain", wg, wh);
    chk("gain_after", o_cp_gain, 5'h01);
    chk("switch_off", oe, 1'b0);
    wr(wd(3'h3, 17'h0_0002, 12'h002));
    watch;
    chk("sync_gap", gap, 80);
    chk("align_at", al, 2);
    wr(wd(3'h1, 17'h0_0003, 12'h001));
    repeat (12) @(negedge i_clk);
    chk("modulus_low", o_fractional_modulus, 12'h002);
    wr(wd(3'h1, 17'h0_0003, 12'hfff));
    repeat (12) @(negedge i_clk);
    chk("modulus_high", o_fractional_modulus, 12'hfff);
    wr(wd(3'h1, 17'h0_0003, 12'h032));
    wr(wd(3'h2, 17'h0_4000, 12'h000));
    repeat (12) @(negedge i_clk);
    chk("dither", o_dither, 1'b1);
    test_done;
  end
endmodule // testbench
